/* File: rtl/cst_pkg.sv */
/*
  Constants and types for the self-test and error guard.
  Assumes a 20 MHz clock and a 32-bit APB register bus.
*/
`default_nettype none
package cst_pkg;
  localparam int          CLK_HZ        = 20_000_000;
  localparam int          POST_LIMIT_S  = 2;
  localparam int          POST_CYC      = POST_LIMIT_S * CLK_HZ;
  localparam int          NUM_KAT       = 6;
  localparam int          MEM_WORDS     = 8;
  localparam int          NUM_REC       = 4;
  localparam logic [15:0] MEM_PATTERN   = 16'hA5C3;
  localparam logic [7:0]  CRC_POLY      = 8'h07;
  localparam logic [7:0]  CRC_INIT      = 8'hFF;
  // Register byte addresses
  localparam logic [11:0] CFG_OFS       = 12'h000;
  localparam logic [11:0] STATUS_OFS    = 12'h004;
  localparam logic [11:0] CMD_OFS       = 12'h008;
  localparam logic [11:0] RNGREF_OFS    = 12'h00C;
  // Configuration bits
  localparam int          CFG_CLR_IMP   = 0;
  localparam int          CFG_CLR_EXP   = 1;
  localparam int          CFG_LRK_GEN   = 2;
  localparam int          CFG_RED_LOAD  = 3;
  localparam logic [3:0]  CFG_RST       = 4'h0;
  localparam int          CMD_ONDEMAND  = 0;
  // Failure causes
  localparam logic [2:0]  FC_NONE       = 3'h0;
  localparam logic [2:0]  FC_MEM        = 3'h1;
  localparam logic [2:0]  FC_FWSIG      = 3'h2;
  localparam logic [2:0]  FC_KAT        = 3'h3;
  localparam logic [2:0]  FC_FWLOAD     = 3'h4;
  localparam logic [2:0]  FC_RNG        = 3'h5;
  localparam logic [2:0]  FC_PAIR       = 3'h6;
  localparam logic [2:0]  FC_TIMEOUT    = 3'h7;
  localparam logic [7:0]  EMSG_BASE     = 8'hE0;

  typedef enum logic [2:0] {
    ST_MEM_WR   = 3'b000,
    ST_MEM_RD   = 3'b001,
    ST_FWSIG    = 3'b010,
    ST_KAT      = 3'b011,
    ST_RNG_INIT = 3'b100,
    ST_RUN      = 3'b101,
    ST_FAIL     = 3'b110
  } cst_state_t;

  // Key record: id 16, algorithm 8, type 1, location 3, plus CRC
  typedef struct packed {
    logic       vld;
    logic [7:0] crc;
    logic [2:0] loc;
    logic       typ;
    logic [7:0] alg;
    logic [15:0] id;
  } cst_rec_t;
endpackage
`default_nettype wire

/* File: rtl/cst_guard.sv */
/*
  Self-test sequencer, critical error guard and key record checker.
  Assumes test engines, random source and output path outside; APB host;
  por_n low only at power-up, rst_n a functional reset.
*/
// What this block does
// RULE1: Output words are blocked in any error state and during self-tests.
// RULE2: Output path isolated while key generation or zeroization runs.
// RULE3: Crypto operations refused or stopped while in an error state.
// RULE4: All power-up tests passed: toggle indicator within two seconds.
// RULE5: Any power-up test failure: critical error, indicator left alone.
// RULE6: Critical error persists until power is cycled.
// RULE7: Random or pair-wise test failure: critical error plus SDIO message; a random failure in the same cycle as a firmware load failure sends none.
// RULE8: First random value at power-up kept only as reference.
// RULE9: New random equal to reference fails; else replaces it, returned.
// RULE10: Known-answer test passes only if result equals expected value.
// RULE11: Power-up write and read-back of working memory; mismatch fails.
// RULE12: Power-up code signature check; mismatch fails integrity test.
// RULE13: New image signature mismatch fails the firmware load test.
// RULE14: Pair-wise sign and verify failure fails the pair-wise test.
// RULE15: Every power cycle runs the whole power-up sequence first.
// RULE16: Clear import, export, loss key, red load or GCM: non-approved.
// RULE17: Clear key import rejected while its setting is off.
// RULE18: Clear key export rejected while its setting is off.
// RULE19: Red loading on key loader port refused while disabled.
// RULE20: Key record holds 16-bit id, 8-bit algorithm, type, location.
// RULE21: Record CRC over all fields detects corruption.
// RULE22: Program update completion zeroizes every stored key.
// RULE23: Reset input returns the block to its reset condition; rst_n keeps crit, lock and fail.
// RULE24: Tamper locks the block with no crypto service.
// RULE25: Critical flag cleared only by power-on reset.
// RULE26: Power-up order memory, firmware, known-answer; stop at failure.
`timescale 1ns/1ps
`default_nettype none
module cst_guard
  import cst_pkg::*;
#(
  parameter logic [25:0] POST_LIMIT_CYC = POST_CYC[25:0]
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  input  wire logic        tamper,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             selftest_ind,
  output logic             crit_err,
  output logic             locked,
  output logic             non_approved,
  output logic             test_busy,
  output logic             fwsig_req,
  input  wire logic        fwsig_done,
  input  wire logic        fwsig_ok,
  output logic             kat_req,
  output logic [2:0]       kat_idx,
  input  wire logic        kat_done,
  input  wire logic [31:0] kat_result,
  input  wire logic [31:0] kat_expect,
  input  wire logic        fwload_done,
  input  wire logic        fwload_ok,
  input  wire logic        pair_done,
  input  wire logic        pair_ok,
  input  wire logic        rng_valid,
  input  wire logic [31:0] rng_data,
  output logic             rng_out_valid,
  output logic [31:0]      rng_out_data,
  input  wire logic        keygen_busy,
  input  wire logic        zeroize_busy,
  input  wire logic        dout_valid_in,
  input  wire logic [31:0] dout_data_in,
  output logic             dout_valid,
  output logic [31:0]      dout_data,
  input  wire logic        op_start,
  input  wire logic        op_gcm,
  output logic             op_grant,
  output logic             op_abort,
  input  wire logic        clear_imp_req,
  output logic             clear_imp_reject,
  input  wire logic        clear_exp_req,
  output logic             clear_exp_reject,
  input  wire logic        key_loader_port_red_req,
  output logic             key_loader_port_red_reject,
  input  wire logic        update_done,
  output logic             zeroize_pulse,
  input  wire logic        rec_wr,
  input  wire logic        rec_rd,
  input  wire logic [1:0]  rec_idx,
  input  wire logic [15:0] rec_key_id,
  input  wire logic [7:0]  rec_alg_id,
  input  wire logic        rec_is_wrap,
  input  wire logic [2:0]  rec_loc,
  output logic             rec_rd_valid,
  output logic             rec_rd_ok,
  output logic             sdio_err_valid,
  output logic [7:0]       sdio_err_code
);

  typedef struct packed {
    cst_state_t                    st;
    logic [3:0]                    cfg;
    logic                          ind;
    logic                          crit;
    logic                          lock;
    logic                          gcm;
    logic                          post_done;
    logic [2:0]                    fail;
    logic [25:0]                   cnt;
    logic [2:0]                    midx;
    logic [2:0]                    kidx;
    logic [MEM_WORDS-1:0][15:0]    mem;
    logic [31:0]                   rref;
    logic                          rvld;
    logic [31:0]                   rout;
    logic                          dvld;
    logic [31:0]                   dat;
    logic                          ev;
    logic [7:0]                    ecode;
    logic                          zer;
    logic [NUM_REC-1:0][36:0]      rec;
    logic                          rrv;
    logic                          rrok;
    logic [31:0]                   prd;
    logic                          perr;
  } cst_regs_t;

  localparam cst_regs_t REGS_RST = '{
    st: ST_MEM_WR, cfg: CFG_RST, fail: FC_NONE, default: '0};

  cst_regs_t s_r;
  cst_regs_t s_nxt;

  // CRC-8 over the 28 field bits of a key record
  function automatic logic [7:0] rec_crc(input logic [27:0] f);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 27; i >= 0; i--) begin
      if (c[7] ^ f[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  logic       err_any;
  logic       out_block;
  logic       setup_ph;
  logic       wr_acc;
  logic       rr_fault;
  logic [2:0] fail_ev;
  cst_rec_t   rd_rec;
  cst_rec_t   wr_rec;

  // RULE1 any error or self-test in progress
  assign err_any   = s_r.crit | s_r.lock;
  assign test_busy = (s_r.st != ST_RUN) & (s_r.st != ST_FAIL);
  // RULE2 isolation during key generation and zeroization
  assign out_block = err_any | test_busy | keygen_busy | zeroize_busy
                     | s_r.zer;
  assign setup_ph  = psel & ~penable;
  assign wr_acc    = psel & penable & pwrite;
  assign rd_rec    = cst_rec_t'(s_r.rec[rec_idx]);

  always_comb begin
    wr_rec     = '0;
    wr_rec.vld = 1'b1;
    // RULE20 record fields
    wr_rec.id  = rec_key_id;
    wr_rec.alg = rec_alg_id;
    wr_rec.typ = rec_is_wrap;
    wr_rec.loc = rec_loc;
    // RULE21 CRC over every field
    wr_rec.crc = rec_crc({rec_loc, rec_is_wrap, rec_alg_id, rec_key_id});
  end

  always_comb begin
    rr_fault = 1'b0;
    fail_ev  = FC_NONE;
    s_nxt    = s_r;
    s_nxt.ev   = 1'b0;
    s_nxt.zer  = 1'b0;
    s_nxt.rvld = 1'b0;
    s_nxt.rrv  = 1'b0;

    // RULE24 tamper lock-up
    if (tamper) begin
      s_nxt.lock = 1'b1;
    end

    case (s_r.st)
      // RULE11 write pattern then read back
      ST_MEM_WR: begin
        s_nxt.mem[s_r.midx] = MEM_PATTERN ^ {13'h0000, s_r.midx};
        s_nxt.midx = s_r.midx + 3'd1;
        if (s_r.midx == 3'(MEM_WORDS - 1)) begin
          s_nxt.st = ST_MEM_RD;
        end
      end
      ST_MEM_RD: begin
        s_nxt.midx = s_r.midx + 3'd1;
        if (s_r.mem[s_r.midx] != (MEM_PATTERN ^ {13'h0000, s_r.midx})) begin
          fail_ev = FC_MEM;
        end else if (s_r.midx == 3'(MEM_WORDS - 1)) begin
          // RULE26 firmware check after memory
          s_nxt.st = ST_FWSIG;
        end
      end
      // RULE12 code signature verification
      ST_FWSIG: begin
        if (fwsig_done && !fwsig_ok) begin
          fail_ev = FC_FWSIG;
        end else if (fwsig_done) begin
          s_nxt.st   = ST_KAT;
          s_nxt.kidx = 3'd0;
        end
      end
      // RULE10 compare with expected answer
      ST_KAT: begin
        if (kat_done && (kat_result != kat_expect)) begin
          fail_ev = FC_KAT;
        end else if (kat_done) begin
          s_nxt.kidx = s_r.kidx + 3'd1;
          if (s_r.kidx == 3'(NUM_KAT - 1)) begin
            s_nxt.st = s_r.post_done ? ST_RUN : ST_RNG_INIT;
          end
        end
      end
      // RULE8 first value only seeds the reference
      ST_RNG_INIT: begin
        if (rng_valid) begin
          s_nxt.rref      = rng_data;
          s_nxt.st        = ST_RUN;
          s_nxt.post_done = 1'b1;
          // RULE4 single toggle on a clean power-up
          s_nxt.ind       = ~s_r.ind;
        end
      end
      ST_RUN: begin
        if (wr_acc && paddr == CMD_OFS && pwdata[CMD_ONDEMAND]) begin
          s_nxt.st   = ST_MEM_WR;
          s_nxt.midx = 3'd0;
        end
      end
      default: begin
        s_nxt.st = ST_FAIL;
      end
    endcase

    // RULE9 continuous random comparison
    if (rng_valid && s_r.st != ST_RNG_INIT && s_r.post_done) begin
      if (rng_data == s_r.rref) begin
        fail_ev = FC_RNG;
      end else begin
        s_nxt.rref = rng_data;
        s_nxt.rout = rng_data;
        s_nxt.rvld = ~out_block;
      end
    end

    // RULE13 new image signature
    if (fwload_done && !fwload_ok) begin
      fail_ev = FC_FWLOAD;
    end
    // RULE14 pair-wise consistency
    if (pair_done && !pair_ok) begin
      fail_ev = FC_PAIR;
    end

    // Timer stops at the first clean pass
    if (!s_r.post_done && !s_r.crit) begin
      s_nxt.cnt = s_r.cnt + 26'd1;
      if (s_r.cnt == POST_LIMIT_CYC - 26'd1) begin
        fail_ev = FC_TIMEOUT;
      end
    end

    // RULE5 failure latches the critical error
    if (fail_ev != FC_NONE && !s_r.crit) begin
      s_nxt.crit = 1'b1;
      s_nxt.fail = fail_ev;
      // RULE7 message on the host port
      if (fail_ev == FC_RNG || fail_ev == FC_PAIR) begin
        s_nxt.ev    = 1'b1;
        s_nxt.ecode = EMSG_BASE | {5'h00, fail_ev};
      end
    end
    // RULE6 no path leaves the failed state
    if (s_nxt.crit) begin
      s_nxt.st = ST_FAIL;
    end

    // RULE16 GCM start is remembered
    if (op_start && op_gcm && op_grant) begin
      s_nxt.gcm = 1'b1;
    end

    // RULE1 output gate, data from flip-flops
    s_nxt.dvld = dout_valid_in & ~out_block;
    s_nxt.dat  = out_block ? 32'h0000_0000 : dout_data_in;

    // RULE22 zeroize on update completion
    if (update_done) begin
      s_nxt.zer = 1'b1;
      for (int i = 0; i < NUM_REC; i++) begin
        s_nxt.rec[i] = '0;
      end
    end else if (rec_wr && !err_any) begin
      s_nxt.rec[rec_idx] = 37'(wr_rec);
    end

    // RULE21 recompute and compare on read
    if (rec_rd) begin
      rr_fault = rd_rec.crc != rec_crc({rd_rec.loc, rd_rec.typ,
                                        rd_rec.alg, rd_rec.id});
      s_nxt.rrv  = 1'b1;
      s_nxt.rrok = rd_rec.vld & ~rr_fault;
    end

    // APB: read data captured in setup, zero wait state
    if (setup_ph) begin
      s_nxt.perr = 1'b0;
      s_nxt.prd  = 32'h0000_0000;
      if (paddr == CFG_OFS) begin
        s_nxt.prd = {28'h000_0000, s_r.cfg};
      end else if (paddr == STATUS_OFS) begin
        s_nxt.prd = {16'h0000, s_r.fail, s_r.st, non_approved,
                     test_busy, s_r.post_done, s_r.ind, s_r.lock,
                     s_r.crit, 4'h0};
      end else if (paddr == CMD_OFS) begin
        s_nxt.prd = 32'h0000_0000;
      end else if (paddr == RNGREF_OFS) begin
        // Reference itself is never exposed, only whether it exists
        s_nxt.prd = {31'h0000_0000, s_r.post_done};
      end else begin
        s_nxt.perr = 1'b1;
      end
    end
    if (wr_acc && paddr == CFG_OFS) begin
      s_nxt.cfg = pwdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    // RULE15 power cycle restarts all tests
    if (!por_n) begin
      s_r <= REGS_RST;
    end else if (!rst_n) begin
      // RULE23 functional reset reruns the sequence, or holds ST_FAIL if crit is set
      s_r <= REGS_RST;
      // RULE25 error and lock survive a functional reset
      s_r.crit <= s_r.crit;
      s_r.lock <= s_r.lock;
      s_r.fail <= s_r.fail;
      s_r.st   <= s_r.crit ? ST_FAIL : ST_MEM_WR;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata        = s_r.prd;
  assign pready        = 1'b1;
  assign pslverr       = psel & penable & s_r.perr;
  assign selftest_ind  = s_r.ind;
  assign crit_err      = s_r.crit;
  assign locked        = s_r.lock;
  // RULE16 non-approved mode
  assign non_approved  = |s_r.cfg | s_r.gcm;
  assign fwsig_req     = s_r.st == ST_FWSIG;
  assign kat_req       = s_r.st == ST_KAT;
  assign kat_idx       = s_r.kidx;
  assign rng_out_valid = s_r.rvld;
  assign rng_out_data  = s_r.rout;
  assign dout_valid    = s_r.dvld;
  assign dout_data     = s_r.dat;
  // RULE3 no crypto in error, lock or test
  assign op_grant      = op_start & ~err_any & ~test_busy;
  assign op_abort      = err_any;
  // RULE17 clear import gate
  assign clear_imp_reject = clear_imp_req & ~s_r.cfg[CFG_CLR_IMP];
  // RULE18 clear export gate
  assign clear_exp_reject = clear_exp_req & ~s_r.cfg[CFG_CLR_EXP];
  // RULE19 red loading gate
  assign key_loader_port_red_reject =
    key_loader_port_red_req & ~s_r.cfg[CFG_RED_LOAD];
  assign zeroize_pulse  = s_r.zer;
  assign rec_rd_valid   = s_r.rrv;
  assign rec_rd_ok      = s_r.rrok;
  assign sdio_err_valid = s_r.ev;
  assign sdio_err_code  = s_r.ecode;

endmodule // cst_guard
`default_nettype wire

/* File: testbench/cst_guard_props.sv */
/*
  Port assertions for cst_guard, bound from the testbench top file.
  Assumes one clock; por_n is power-on reset, rst_n a functional reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cst_guard_props (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        por_n,
  input wire logic        tamper,
  input wire logic        op_start,
  input wire logic        op_grant,
  input wire logic        op_abort,
  input wire logic        crit_err,
  input wire logic        locked,
  input wire logic        test_busy,
  input wire logic        dout_valid,
  input wire logic        dout_valid_in,
  input wire logic        keygen_busy,
  input wire logic        zeroize_busy,
  input wire logic        selftest_ind,
  input wire logic        rng_valid,
  input wire logic [31:0] rng_data,
  input wire logic        rng_out_valid,
  input wire logic [31:0] rng_out_data,
  input wire logic        sdio_err_valid,
  input wire logic        clear_imp_req,
  input wire logic        clear_imp_reject,
  input wire logic        non_approved,
  input wire logic        update_done,
  input wire logic        zeroize_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !por_n);

  a_out_block: assert property (
    dout_valid |-> $past(dout_valid_in) && !$past(test_busy)
      && !$past(crit_err) && !$past(keygen_busy) && !$past(zeroize_busy))
    else $error("output word passed while blocked");
  a_grant_gate: assert property (
    op_grant |-> op_start && !crit_err && !locked && !test_busy)
    else $error("operation granted in error, lock or test");
  a_abort_err: assert property (
    crit_err || locked |-> op_abort)
    else $error("operation not stopped in error state");
  // Functional reset must not clear it, so only por_n disables
  a_crit_sticky: assert property (
    disable iff (!por_n) crit_err |=> crit_err)
    else $error("critical error cleared without power cycle");
  a_lock_hold: assert property (
    disable iff (!por_n) tamper || locked |=> locked)
    else $error("tamper lock missing or released");
  a_ind_pass: assert property (
    $rose(selftest_ind) |-> !test_busy && !crit_err)
    else $error("indicator toggled without passing tests");
  a_rng_fwd: assert property (
    rng_out_valid |-> $past(rng_valid) && rng_out_data == $past(rng_data))
    else $error("random output not the value taken one cycle before");
  a_sdio_crit: assert property (
    sdio_err_valid |-> ##[0:1] crit_err)
    else $error("error message without critical error");
  a_imp_rej: assert property (
    clear_imp_req && !non_approved |-> clear_imp_reject)
    else $error("clear import accepted while disabled");
  a_zeroize: assert property (
    update_done |=> zeroize_pulse)
    else $error("update finished without zeroize");
endmodule // cst_guard_props
`default_nettype wire

/* File: testbench/cst_engine_model.sv */
/*
  Stand-in for the signature and known-answer engines.
  Assumes level requests; result lines wander outside the done cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module cst_engine_model (
  input  wire logic        clk,
  input  wire logic        fwsig_req,
  input  wire logic        kat_req,
  input  wire logic [2:0]  kat_idx,
  input  wire logic        fw_good,
  input  wire logic [2:0]  bad_kat,
  output logic             fwsig_done,
  output logic             fwsig_ok,
  output logic             kat_done,
  output logic [31:0]      kat_result,
  output logic [31:0]      kat_expect
);
  logic [1:0]  cnt = '0;
  logic [31:0] pat = 32'h1357_9BDF;
  always @(posedge clk) begin
    pat <= {pat[30:0], pat[31]} ^ 32'h0000_0001;
    cnt <= (fwsig_req || kat_req) ? cnt + 2'h1 : '0;
  end
  // Answer after three busy cycles, so each index is seen once
  assign fwsig_done = fwsig_req && cnt == 2'h3;
  assign fwsig_ok = fwsig_done ? fw_good : pat[0];
  assign kat_done = kat_req && cnt == 2'h3;
  assign kat_expect = kat_done ? {29'h0, kat_idx} ^ 32'hC0DE_0000 : pat;
  assign kat_result = kat_expect ^ {31'h0, kat_done && kat_idx == bad_kat};
endmodule // cst_engine_model
`default_nettype wire

/* File: testbench/tb.sv */
/*
  Top testbench for cst_guard: scenario tasks and an APB master.
  Assumes the engine model answers the self-test requests.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cst_pkg::*;
  logic        clk = '0, rst_n = '0, por_n = '0, tamper = '0, psel = '0;
  logic        penable = '0, pwrite = '0, fwload_done = '0, fwload_ok = '0;
  logic        pair_done = '0, pair_ok = '0, rng_valid = '0, op_start = '0;
  logic        keygen_busy = '0, zeroize_busy = '0, dout_valid_in = '0;
  logic        op_gcm = '0, clear_imp_req = '0, clear_exp_req = '0;
  logic        key_loader_port_red_req = '0, update_done = '0, rec_wr = '0;
  logic        rec_rd = '0, rec_is_wrap = '0, fw_good = '1, er, kat_seen;
  logic [1:0]  rec_idx = '0;
  logic [2:0]  rec_loc = '0, bad_kat = 3'h7, kat_idx;
  logic [7:0]  rec_alg_id = '0, sdio_err_code, sdio_seen = '0;
  logic [11:0] paddr = '0;
  logic [15:0] rec_key_id = '0;
  logic [31:0] pwdata = '0, rng_data = '0, dout_data_in = '0, rd;
  logic [31:0] prdata, kat_result, kat_expect, rng_out_data, dout_data;
  logic        pready, pslverr, selftest_ind, crit_err, locked, non_approved;
  logic        test_busy, fwsig_req, kat_req, rng_out_valid, dout_valid;
  logic        op_grant, op_abort, clear_imp_reject, clear_exp_reject;
  logic        key_loader_port_red_reject, zeroize_pulse, rec_rd_valid;
  logic        rec_rd_ok, sdio_err_valid, fwsig_done, fwsig_ok, kat_done;
  int          miscompares = 0, n_checks = 0;

  cst_guard #(.POST_LIMIT_CYC(26'h7D0)) cst_guard_i (.*);
  cst_engine_model cst_engine_model_i (.*);

  always #25 clk = ~clk;
  always @(posedge clk) begin
    kat_seen <= por_n && (kat_seen || kat_req === 1'b1);
    if (sdio_err_valid === 1'b1) sdio_seen <= sdio_err_code;
  end

  task automatic print_verdict;
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= '1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= '1;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        miscompares++;
        print_verdict;
      end
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= '0;
    penable <= '0;
  endtask

  // Power cycle, feeding random words until the tests settle
  task automatic powerup(logic fw, logic [2:0] bk);
    int i;
    @(posedge clk);
    fw_good <= fw;
    bad_kat <= bk;
    por_n <= '0;
    rst_n <= '0;
    repeat (4) @(posedge clk);
    por_n <= '1;
    rst_n <= '1;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      rng_valid <= (i % 4 == 3);
      rng_data <= 32'h0000_0100 + i;
      #1;
      if (test_busy !== 1'b1) break;
    end
    @(posedge clk);
    rng_valid <= '0;
    #1;
    if (i == 400) begin
      miscompares++;
      print_verdict;
    end
  endtask

  task automatic rst_pulse;
    @(posedge clk);
    rst_n <= '0;
    @(posedge clk);
    rst_n <= '1;
    @(posedge clk);
    #1;
  endtask

  task automatic rng_pulse(logic [31:0] d);
    @(posedge clk);
    rng_valid <= '1;
    rng_data <= d;
    @(posedge clk);
    rng_valid <= '0;
    #1;
  endtask

  task automatic t_pass;
    powerup(1'b1, 3'h7);
    chk("busy", test_busy, 1'b0);
    chk("ind", selftest_ind, 1'b1);
    apb(1'b0, STATUS_OFS, '0);
    chk("status", rd, 32'h0000_14C0);
    apb(1'b0, RNGREF_OFS, '0);
    chk("seeded", rd[0], 1'b1);
    apb(1'b1, CMD_OFS, 32'h0000_0001);
    #1;
    chk("ondemand", test_busy, 1'b1);
    repeat (60) @(posedge clk);
    #1;
    chk("ondone", {test_busy, selftest_ind, crit_err}, 3'h2);
  endtask

  task automatic t_cfg;
    int k;
    clear_imp_req <= '1;
    clear_exp_req <= '1;
    key_loader_port_red_req <= '1;
    for (k = 0; k < 4; k++) begin
      apb(1'b1, CFG_OFS, 32'h0000_0001 << k);
      #1;
      chk("na", non_approved, 1'b1);
      chk("rej", {clear_imp_reject, clear_exp_reject,
        key_loader_port_red_reject}, {k != 0, k != 1, k != 3});
    end
    apb(1'b1, CFG_OFS, '0);
    #1;
    chk("imp", clear_imp_reject, 1'b1);
    chk("exp", clear_exp_reject, 1'b1);
    chk("red", key_loader_port_red_reject, 1'b1);
    apb(1'b0, 12'hFF0, '0);
    chk("unmapped", {er, rd}, {1'b1, 32'h0});
    @(posedge clk);
    op_start <= '1;
    op_gcm <= '1;
    @(posedge clk);
    op_start <= '0;
    op_gcm <= '0;
    @(posedge clk);
    #1;
    chk("gcm", non_approved, 1'b1);
  endtask

  task automatic t_rec;
    @(posedge clk);
    rec_wr <= '1;
    rec_idx <= 2'h3;
    rec_key_id <= 16'hBEEF;
    rec_alg_id <= 8'h84;
    rec_is_wrap <= '1;
    rec_loc <= 3'h5;
    @(posedge clk);
    rec_wr <= '0;
    rec_rd <= '1;
    @(posedge clk);
    rec_rd <= '0;
    update_done <= '1;
    #1;
    chk("rec", {rec_rd_valid, rec_rd_ok}, 2'h3);
    @(posedge clk);
    update_done <= '0;
    rec_rd <= '1;
    #1;
    chk("zero", zeroize_pulse, 1'b1);
    @(posedge clk);
    rec_rd <= '0;
    #1;
    chk("rec", {rec_rd_valid, rec_rd_ok}, 2'h2);
  endtask

  task automatic t_out;
    @(posedge clk);
    op_start <= '1;
    dout_valid_in <= '1;
    dout_data_in <= 32'hCAFE_0001;
    @(posedge clk);
    keygen_busy <= '1;
    #1;
    chk("grant", op_grant, 1'b1);
    chk("dout", dout_data, 32'hCAFE_0001);
    @(posedge clk);
    keygen_busy <= '0;
    zeroize_busy <= '1;
    #1;
    chk("keygen", dout_valid, 1'b0);
    @(posedge clk);
    zeroize_busy <= '0;
    #1;
    chk("zeroize", dout_valid, 1'b0);
  endtask

  task automatic t_rng;
    rng_pulse(32'h5A5A_0001);
    chk("rng", rng_out_valid, 1'b1);
    chk("rngd", rng_out_data, 32'h5A5A_0001);
    rng_pulse(32'h5A5A_0001);
    repeat (2) @(posedge clk);
    #1;
    chk("crit", crit_err, 1'b1);
    chk("msg", sdio_seen, 8'hE5);
    chk("dout", dout_valid, 1'b0);
    chk("stop", {op_grant, op_abort}, 2'h1);
    rst_pulse;
    chk("crit", {crit_err, test_busy}, 2'h2);
    apb(1'b0, STATUS_OFS, '0);
    chk("cause", rd[15:13], FC_RNG);
  endtask

  task automatic t_fail;
    powerup(1'b1, 3'h5);
    chk("kat", {crit_err, selftest_ind}, 2'h2);
    apb(1'b0, STATUS_OFS, '0);
    chk("cause", rd[15:13], FC_KAT);
    powerup(1'b0, 3'h7);
    chk("fw", {crit_err, selftest_ind, kat_seen}, 3'h4);
    apb(1'b0, STATUS_OFS, '0);
    chk("cause", rd[15:13], FC_FWSIG);
  endtask

  task automatic t_cond;
    int k;
    for (k = 0; k < 2; k++) begin
      powerup(1'b1, 3'h7);
      @(posedge clk);
      fwload_done <= (k == 0);
      pair_done <= (k == 1);
      @(posedge clk);
      fwload_done <= '0;
      pair_done <= '0;
      apb(1'b0, STATUS_OFS, '0);
      chk("cause", rd[15:13], k ? FC_PAIR : FC_FWLOAD);
    end
    chk("msg", sdio_seen, 8'hE6);
  endtask

  task automatic t_tamper;
    powerup(1'b1, 3'h7);
    @(posedge clk);
    tamper <= '1;
    @(posedge clk);
    tamper <= '0;
    @(posedge clk);
    #1;
    chk("lock", {locked, op_grant, op_abort}, 3'h5);
    rst_pulse;
    chk("reset", {locked, selftest_ind, test_busy}, 3'h5);
  endtask

  initial begin
    t_pass;
    t_cfg;
    t_rec;
    t_out;
    t_rng;
    t_fail;
    t_cond;
    t_tamper;
    print_verdict;
  end
endmodule // tb

bind cst_guard cst_guard_props cst_guard_props_i (.*);
`default_nettype wire
